// ---- rtl/oss_overlay_space_select.sv ----
// Operation
// RULE_01: write 0x0098 at word 0x555 enters query space; 0x00f0 anywhere leaves it.
// RULE_02: query data only for reads in the sector given at entry.
// RULE_03: status read command snapshots status and enters status space.
// RULE_04: first read in status space exits to the previous map.
// RULE_05: status only on first burst word; later words indeterminate.
// RULE_06: host reads status before sending any further command.
// RULE_07: secure space overlays entry sector; beyond the region reads indeterminate.
// RULE_08: secure space reads of other sectors give array and stay entered.
// RULE_09: secure region takes word and buffer program; exits on two commands.
// RULE_10: lock-family entries only from read mode, ignoring sector address.
// RULE_11: protection config at word 0, modified program; other words undefined.
// RULE_12: password at words 0 to 3, modified program; others undefined.
// RULE_13: password space accepts unlock releasing the global guard bit.
// RULE_14: persistent lock in bit 0 per sector; program sets, erase clears all.
// RULE_15: guard space shows guard bit in bit 0; modified program clears it.
// RULE_16: volatile lock in bit 0 per sector; set or clear by program.
// RULE_17: lock-family spaces exit on legacy exit or common exit.
// RULE_18: ecc space shows half-page status bits 4:0, traps and counter.
// RULE_19: crc running overlays whole array; suspended allows array reads only.
// RULE_20: crc space takes start, end, suspend, resume, read value, exit.
// RULE_21: software reset to standby, leaves query, clears timeout; ignored while busy.
// RULE_22: software reset acts within the write pulse high interval.
// RULE_23: after error clear stay in overlay, else erase suspend, else standby.
// RULE_24: one overlay at a time; read address decoded against it first.
`timescale 1ns/100ps
`default_nettype none
module oss_overlay_space_select #(
   parameter int SECT_W = 8,
   parameter int WORD_W = 12,
   parameter int SEC_WORDS = 512,
   parameter int HP_W = 4
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_b,
   input  wire logic                  i_cmd_valid,
   input  wire logic [SECT_W-1:0]     i_cmd_sector,
   input  wire logic [WORD_W-1:0]     i_cmd_word,
   input  wire logic [15:0]           i_cmd_data,
   input  wire logic                  i_rd_start,
   input  wire logic                  i_rd_beat,
   input  wire logic [SECT_W-1:0]     i_rd_sector,
   input  wire logic [WORD_W-1:0]     i_rd_word,
   input  wire logic [15:0]           i_status,
   input  wire logic                  i_op_busy,
   input  wire logic                  i_erase_susp,
   input  wire logic                  i_err_active,
   input  wire logic                  i_timeout_set,
   output logic [3:0]                 o_space,
   output logic [3:0]                 o_rd_src,
   output logic [15:0]                o_rd_word,
   output logic                       o_rd_undef,
   output logic                       o_sec_prog,
   output logic                       o_pcfg_prog,
   output logic                       o_pwd_prog,
   output logic                       o_pwd_unlock,
   output logic                       o_crc_cmd,
   output logic [2:0]                 o_crc_code,
   output logic                       o_crc_susp,
   output logic                       o_ctrl_standby,
   output logic                       o_erase_susp_state,
   output logic                       o_timeout_flag,
   output logic                       o_guard_bit,
   output logic [(1<<SECT_W)-1:0]     o_plk,
   output logic [(1<<SECT_W)-1:0]     o_vlk
);
   typedef struct packed {
      oss_pkg::oss_space_t         space;
      oss_pkg::oss_space_t         prev;
      logic [SECT_W-1:0]           sect;
      logic [15:0]                 snap;
      logic                        stat_first;
      logic                        prog_arm;
      logic                        crc_susp;
      logic                        timeout;
      logic                        guard;
      logic [(1<<SECT_W)-1:0]      plk;
      logic [(1<<SECT_W)-1:0]      vlk;
      logic [3:0]                  src;
      logic [15:0]                 rdw;
      logic                        undef;
      logic                        sec_prog;
      logic                        pcfg_prog;
      logic                        pwd_prog;
      logic                        unlock;
      logic                        crc_cmd;
      logic [2:0]                  crc_code;
      logic                        standby;
      logic                        esusp;
   } oss_state_t;
   oss_state_t st_r;
   oss_state_t st_nxt;
   logic       in_read_mode;
   logic       exit_any;
   logic       legacy_exit;
   always_comb begin
      st_nxt = st_r;
      st_nxt.sec_prog = 1'b0;
      st_nxt.pcfg_prog = 1'b0;
      st_nxt.pwd_prog = 1'b0;
      st_nxt.unlock = 1'b0;
      st_nxt.crc_cmd = 1'b0;
      in_read_mode = (st_r.space == oss_pkg::OSS_ARRAY) && !i_op_busy;
      exit_any = i_cmd_data == oss_pkg::CMD_EXIT;
      legacy_exit = i_cmd_data == oss_pkg::CMD_LEG_EXIT;
      if (i_timeout_set) begin
         st_nxt.timeout = 1'b1;
      end
      st_nxt.standby = !i_op_busy && !i_erase_susp;
      st_nxt.esusp = i_erase_susp && !i_op_busy;
      if (i_cmd_valid) begin
         if (exit_any && !i_op_busy) begin
            // software reset / common exit, same cycle as the write [RULE_21] [RULE_22]
            if (st_r.space != oss_pkg::OSS_STAT) begin
               st_nxt.space = oss_pkg::OSS_ARRAY; // [RULE_01] [RULE_17]
            end
            st_nxt.timeout = i_timeout_set; // [RULE_21]
            st_nxt.prog_arm = 1'b0;
         end else if (i_cmd_data == oss_pkg::CMD_SR_READ) begin
            st_nxt.snap = i_status; // [RULE_03]
            st_nxt.stat_first = 1'b1;
            if (st_r.space != oss_pkg::OSS_STAT) begin
               st_nxt.prev = st_r.space; // [RULE_04]
            end
            st_nxt.space = oss_pkg::OSS_STAT; // [RULE_03]
         end else if (i_cmd_data == oss_pkg::CMD_SR_CLEAR && i_err_active) begin
            // overlay kept; standby or suspend follows the controller [RULE_23]
            st_nxt.space = st_r.space;
         end else if (st_r.prog_arm) begin
            st_nxt.prog_arm = 1'b0;
            unique case (st_r.space)
               oss_pkg::OSS_SEC: st_nxt.sec_prog = 1'b1; // [RULE_09]
               oss_pkg::OSS_PCFG: st_nxt.pcfg_prog = (i_cmd_word == '0); // [RULE_11]
               oss_pkg::OSS_PWD: st_nxt.pwd_prog = (i_cmd_word <= oss_pkg::PWD_LAST_WORD); // [RULE_12]
               oss_pkg::OSS_PLK: st_nxt.plk[i_cmd_sector] = 1'b1; // [RULE_14]
               oss_pkg::OSS_GRD: st_nxt.guard = st_r.guard & i_cmd_data[0]; // [RULE_15]
               oss_pkg::OSS_VLK: st_nxt.vlk[i_cmd_sector] = i_cmd_data[0]; // [RULE_16]
               default: st_nxt.prog_arm = 1'b0;
            endcase
         end else if (in_read_mode) begin
            // entries only from read mode; one overlay at a time [RULE_24]
            if (i_cmd_data == oss_pkg::CMD_ID_ENTRY && i_cmd_word == oss_pkg::ADDR_ID_ENTRY) begin
               st_nxt.space = oss_pkg::OSS_IDQ; // [RULE_01]
               st_nxt.sect = i_cmd_sector; // [RULE_02]
            end else if (i_cmd_data == oss_pkg::CMD_SEC_ENTRY) begin
               st_nxt.space = oss_pkg::OSS_SEC;
               st_nxt.sect = i_cmd_sector; // [RULE_07]
            end else if (i_cmd_data == oss_pkg::CMD_PCFG_ENTRY) begin
               st_nxt.space = oss_pkg::OSS_PCFG; // [RULE_10]
            end else if (i_cmd_data == oss_pkg::CMD_PWD_ENTRY) begin
               st_nxt.space = oss_pkg::OSS_PWD; // [RULE_10]
            end else if (i_cmd_data == oss_pkg::CMD_PLK_ENTRY) begin
               st_nxt.space = oss_pkg::OSS_PLK; // [RULE_10]
            end else if (i_cmd_data == oss_pkg::CMD_GRD_ENTRY) begin
               st_nxt.space = oss_pkg::OSS_GRD; // [RULE_10]
            end else if (i_cmd_data == oss_pkg::CMD_VLK_ENTRY) begin
               st_nxt.space = oss_pkg::OSS_VLK; // [RULE_10]
            end else if (i_cmd_data == oss_pkg::CMD_ECC_ENTRY) begin
               st_nxt.space = oss_pkg::OSS_ECC; // [RULE_10]
            end else if (i_cmd_data == oss_pkg::CMD_CRC_ENTRY) begin
               st_nxt.space = oss_pkg::OSS_CRC;
               st_nxt.crc_susp = 1'b0;
            end
         end else begin
            unique case (st_r.space)
               oss_pkg::OSS_SEC: begin
                  if (legacy_exit) begin
                     st_nxt.space = oss_pkg::OSS_ARRAY; // [RULE_09]
                  end else if (i_cmd_data == oss_pkg::CMD_PROG || i_cmd_data == oss_pkg::CMD_BUF_PROG) begin
                     st_nxt.prog_arm = 1'b1; // [RULE_09]
                  end
               end
               oss_pkg::OSS_PCFG, oss_pkg::OSS_PWD, oss_pkg::OSS_PLK,
               oss_pkg::OSS_GRD, oss_pkg::OSS_VLK: begin
                  if (legacy_exit) begin
                     st_nxt.space = oss_pkg::OSS_ARRAY; // [RULE_17]
                  end else if (i_cmd_data == oss_pkg::CMD_PROG) begin
                     st_nxt.prog_arm = 1'b1;
                  end else if (i_cmd_data == oss_pkg::CMD_PWD_UNLOCK && st_r.space == oss_pkg::OSS_PWD) begin
                     st_nxt.unlock = 1'b1; // [RULE_13]
                     st_nxt.guard = 1'b0; // [RULE_13]
                  end else if (i_cmd_data == oss_pkg::CMD_PLK_ERASE && st_r.space == oss_pkg::OSS_PLK) begin
                     st_nxt.plk = '0; // [RULE_14]
                  end
               end
               oss_pkg::OSS_CRC: begin
                  // crc command set [RULE_20]
                  st_nxt.crc_cmd = 1'b1;
                  if (i_cmd_data == oss_pkg::CMD_CRC_START) begin
                     st_nxt.crc_code = 3'h1;
                  end else if (i_cmd_data == oss_pkg::CMD_CRC_END) begin
                     st_nxt.crc_code = 3'h2;
                  end else if (i_cmd_data == oss_pkg::CMD_CRC_SUSP) begin
                     st_nxt.crc_code = 3'h3;
                     st_nxt.crc_susp = 1'b1;
                  end else if (i_cmd_data == oss_pkg::CMD_CRC_RESUME) begin
                     st_nxt.crc_code = 3'h4;
                     st_nxt.crc_susp = 1'b0;
                  end else if (i_cmd_data == oss_pkg::CMD_CRC_RDVAL) begin
                     st_nxt.crc_code = 3'h5;
                  end else begin
                     st_nxt.crc_cmd = 1'b0;
                  end
               end
               default: st_nxt.prog_arm = 1'b0;
            endcase
         end
      end
      // read decode against active overlay first [RULE_24]
      if (i_rd_start || i_rd_beat) begin
         st_nxt.undef = 1'b0;
         st_nxt.rdw = '0;
         st_nxt.src = oss_pkg::SRC_ARRAY;
         unique case (st_r.space)
            oss_pkg::OSS_IDQ: begin
               st_nxt.src = (i_rd_sector == st_r.sect) ? oss_pkg::SRC_QUERY : oss_pkg::SRC_ARRAY; // [RULE_02]
            end
            oss_pkg::OSS_STAT: begin
               st_nxt.src = oss_pkg::SRC_STAT;
               st_nxt.rdw = i_rd_start ? st_r.snap : 16'h0000; // [RULE_05]
               st_nxt.undef = !i_rd_start; // [RULE_05]
               if (i_rd_start) begin
                  st_nxt.space = st_r.prev; // [RULE_04]
                  st_nxt.stat_first = 1'b0;
               end
            end
            oss_pkg::OSS_SEC: begin
               if (i_rd_sector == st_r.sect) begin
                  st_nxt.src = oss_pkg::SRC_SEC;
                  st_nxt.undef = int'(i_rd_word) >= SEC_WORDS; // [RULE_07]
               end
               // other sectors read array, overlay kept [RULE_08]
            end
            oss_pkg::OSS_PCFG: begin
               st_nxt.src = oss_pkg::SRC_PCFG;
               st_nxt.undef = (i_rd_word != '0) || (i_rd_sector != '0); // [RULE_11]
            end
            oss_pkg::OSS_PWD: begin
               st_nxt.src = oss_pkg::SRC_PWD;
               st_nxt.undef = (i_rd_word > oss_pkg::PWD_LAST_WORD) || (i_rd_sector != '0); // [RULE_12]
            end
            oss_pkg::OSS_PLK: begin
               st_nxt.src = oss_pkg::SRC_LOCK;
               st_nxt.rdw = {15'h0000, st_r.plk[i_rd_sector]}; // [RULE_14]
            end
            oss_pkg::OSS_GRD: begin
               st_nxt.src = oss_pkg::SRC_LOCK;
               st_nxt.rdw = {15'h0000, st_r.guard}; // [RULE_15]
            end
            oss_pkg::OSS_VLK: begin
               st_nxt.src = oss_pkg::SRC_LOCK;
               st_nxt.rdw = {15'h0000, st_r.vlk[i_rd_sector]}; // [RULE_16]
            end
            oss_pkg::OSS_ECC: begin
               st_nxt.src = oss_pkg::SRC_ECC; // [RULE_18]
            end
            oss_pkg::OSS_CRC: begin
               st_nxt.src = st_r.crc_susp ? oss_pkg::SRC_ARRAY : oss_pkg::SRC_CRC; // [RULE_19]
            end
            default: st_nxt.src = oss_pkg::SRC_ARRAY;
         endcase
      end
      if (!i_rst_b) begin
         st_nxt = '0;
         st_nxt.guard = 1'b1;
         st_nxt.standby = 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      st_r <= st_nxt;
   end
   assign o_space = st_r.space;
   assign o_rd_src = st_r.src;
   assign o_rd_word = st_r.rdw;
   assign o_rd_undef = st_r.undef;
   assign o_sec_prog = st_r.sec_prog;
   assign o_pcfg_prog = st_r.pcfg_prog;
   assign o_pwd_prog = st_r.pwd_prog;
   assign o_pwd_unlock = st_r.unlock;
   assign o_crc_cmd = st_r.crc_cmd;
   assign o_crc_code = st_r.crc_code;
   assign o_crc_susp = st_r.crc_susp;
   assign o_ctrl_standby = st_r.standby;
   assign o_erase_susp_state = st_r.esusp;
   assign o_timeout_flag = st_r.timeout;
   assign o_guard_bit = st_r.guard;
   assign o_plk = st_r.plk;
   assign o_vlk = st_r.vlk;

   a_status_first_exit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (st_r.space == oss_pkg::OSS_STAT && i_rd_start) |=> st_r.space == $past(st_r.prev))
      else $error("status space not left on first read"); // [RULE_04]
   a_status_snapshot: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_cmd_valid && i_cmd_data == oss_pkg::CMD_SR_READ) |=> st_r.snap == $past(i_status))
      else $error("status not captured"); // [RULE_03]
   a_query_entry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_cmd_valid && in_read_mode && i_cmd_data == oss_pkg::CMD_ID_ENTRY
       && i_cmd_word == oss_pkg::ADDR_ID_ENTRY) |=> st_r.space == oss_pkg::OSS_IDQ)
      else $error("query entry missed"); // [RULE_01]
   a_reset_exit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_cmd_valid && exit_any && !i_op_busy && st_r.space != oss_pkg::OSS_STAT)
      |=> (st_r.space == oss_pkg::OSS_ARRAY && !st_r.timeout) || $past(i_timeout_set))
      else $error("software reset not taken"); // [RULE_21]
   a_busy_no_entry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (st_r.space == oss_pkg::OSS_ARRAY && i_op_busy && i_cmd_data != oss_pkg::CMD_SR_READ)
      |=> st_r.space == oss_pkg::OSS_ARRAY)
      else $error("entry accepted outside read mode"); // [RULE_10]
   a_unlock_guard: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st_r.unlock |-> !st_r.guard)
      else $error("unlock left guard set"); // [RULE_13]
   a_sec_other_sector: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (st_r.space == oss_pkg::OSS_SEC && i_rd_start && !i_cmd_valid && i_rd_sector != st_r.sect)
      |=> st_r.space == oss_pkg::OSS_SEC && st_r.src == oss_pkg::SRC_ARRAY)
      else $error("secure space left on array read"); // [RULE_08]
   a_crc_susp_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (st_r.space == oss_pkg::OSS_CRC && i_rd_start && !i_cmd_valid)
      |=> st_r.src == ($past(st_r.crc_susp) ? oss_pkg::SRC_ARRAY : oss_pkg::SRC_CRC))
      else $error("crc read source wrong"); // [RULE_19]
endmodule
`default_nettype wire

// ---- rtl/oss_pkg.sv ----
package oss_pkg;
   // command data words (matched on all 16 bits)
   localparam logic [15:0] CMD_ID_ENTRY    = 16'h0098;
   localparam logic [15:0] CMD_EXIT        = 16'h00f0;
   localparam logic [15:0] CMD_SR_READ     = 16'h0070;
   localparam logic [15:0] CMD_SR_CLEAR    = 16'h0071;
   localparam logic [15:0] CMD_SEC_ENTRY   = 16'h0088;
   localparam logic [15:0] CMD_SEC_EXIT    = 16'h0090;
   localparam logic [15:0] CMD_PCFG_ENTRY  = 16'h0040;
   localparam logic [15:0] CMD_PWD_ENTRY   = 16'h0060;
   localparam logic [15:0] CMD_PLK_ENTRY   = 16'h00c0;
   localparam logic [15:0] CMD_GRD_ENTRY   = 16'h0050;
   localparam logic [15:0] CMD_VLK_ENTRY   = 16'h00e0;
   localparam logic [15:0] CMD_ECC_ENTRY   = 16'h0075;
   localparam logic [15:0] CMD_CRC_ENTRY   = 16'h0078;
   localparam logic [15:0] CMD_LEG_EXIT    = 16'h0090;
   localparam logic [15:0] CMD_PROG        = 16'h00a0;
   localparam logic [15:0] CMD_BUF_PROG    = 16'h0025;
   localparam logic [15:0] CMD_PLK_ERASE   = 16'h0080;
   localparam logic [15:0] CMD_PWD_UNLOCK  = 16'h0029;
   localparam logic [15:0] CMD_CRC_START   = 16'h00c3;
   localparam logic [15:0] CMD_CRC_END     = 16'h003c;
   localparam logic [15:0] CMD_CRC_SUSP    = 16'h00b0;
   localparam logic [15:0] CMD_CRC_RESUME  = 16'h0030;
   localparam logic [15:0] CMD_CRC_RDVAL   = 16'h0079;
   // entry address for identity query entry
   localparam logic [11:0] ADDR_ID_ENTRY   = 12'h555;
   // password words 0..3
   localparam logic [11:0] PWD_LAST_WORD   = 12'h003;
   typedef enum logic [3:0] {
      OSS_ARRAY = 4'h0,
      OSS_IDQ   = 4'h1,
      OSS_STAT  = 4'h2,
      OSS_SEC   = 4'h3,
      OSS_PCFG  = 4'h4,
      OSS_PWD   = 4'h5,
      OSS_PLK   = 4'h6,
      OSS_GRD   = 4'h7,
      OSS_VLK   = 4'h8,
      OSS_ECC   = 4'h9,
      OSS_CRC   = 4'ha
   } oss_space_t;
   // read source selection
   typedef enum logic [3:0] {
      SRC_ARRAY = 4'h0,
      SRC_QUERY = 4'h1,
      SRC_STAT  = 4'h2,
      SRC_SEC   = 4'h3,
      SRC_PCFG  = 4'h4,
      SRC_PWD   = 4'h5,
      SRC_LOCK  = 4'h6,
      SRC_ECC   = 4'h7,
      SRC_CRC   = 4'h8,
      SRC_UNDEF = 4'h9
   } oss_src_t;
endpackage

// ---- test/oss_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module oss_host_model #(
   parameter int SECT_W = 8,
   parameter int WORD_W = 12
) (
   input  wire logic              i_clk,
   output var  logic              o_cmd_valid,
   output var  logic [SECT_W-1:0] o_cmd_sector,
   output var  logic [WORD_W-1:0] o_cmd_word,
   output var  logic [15:0]       o_cmd_data,
   output var  logic              o_rd_start,
   output var  logic              o_rd_beat,
   output var  logic [SECT_W-1:0] o_rd_sector,
   output var  logic [WORD_W-1:0] o_rd_word
);
   logic stat_owed;
   initial begin
      {o_cmd_valid, o_rd_start, o_rd_beat, stat_owed} = '0;
      {o_cmd_sector, o_cmd_word, o_cmd_data, o_rd_sector, o_rd_word} = '0;
   end
   // random idle cycles: prompt and slow hosts alike
   task automatic idle();
      repeat ($urandom_range(2, 0)) @(posedge i_clk);
      @(posedge i_clk);
      #1;
   endtask
   task automatic rd(input logic first, input logic [SECT_W-1:0] s, input logic [WORD_W-1:0] w);
      idle();
      {o_rd_start, o_rd_beat} = {first, ~first};
      o_rd_sector = s;
      o_rd_word = w;
      stat_owed = 1'b0;
      @(posedge i_clk);
      #1;
      {o_rd_start, o_rd_beat} = 2'b00;
      o_rd_sector = ~s;
      o_rd_word = ~w;
   endtask
   task automatic wr(input logic [SECT_W-1:0] s, input logic [WORD_W-1:0] w, input logic [15:0] d);
      if (stat_owed) rd(1'b1, '0, '0);  // owed status read first
      idle();
      o_cmd_valid = 1'b1;
      o_cmd_sector = s;
      o_cmd_word = w;
      o_cmd_data = d;
      @(posedge i_clk);
      #1;
      o_cmd_valid = 1'b0;
      o_cmd_sector = ~s;
      o_cmd_word = ~w;
      o_cmd_data = ~d;
      stat_owed = (d == oss_pkg::CMD_SR_READ);
   endtask
endmodule
`default_nettype wire

// ---- test/oss_overlay_space_select_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) chk_val(32'(act), 32'(exp))
module oss_overlay_space_select_bench;
   localparam int SW = 8;
   localparam int WW = 12;
   localparam int SECW = 512;
   logic i_clk, i_rst_b, i_op_busy, i_erase_susp, i_err_active, i_timeout_set;
   logic i_cmd_valid, i_rd_start, i_rd_beat, o_rd_undef, o_sec_prog, o_pcfg_prog, o_pwd_prog;
   logic o_pwd_unlock, o_crc_cmd, o_crc_susp, o_ctrl_standby, o_erase_susp_state;
   logic o_timeout_flag, o_guard_bit, taken_q;
   logic [SW-1:0] i_cmd_sector, i_rd_sector, s;
   logic [WW-1:0] i_cmd_word, i_rd_word;
   logic [15:0] i_cmd_data, i_status, o_rd_word, snap;
   logic [3:0] o_space, o_rd_src;
   logic [2:0] o_crc_code;
   logic [(1<<SW)-1:0] o_plk, o_vlk;
   logic [22:0] exp_q[$];
   logic [22:0] e;
   int n_mismatch, num_checks;
   logic [15:0] ent [6] = '{oss_pkg::CMD_ECC_ENTRY, oss_pkg::CMD_PCFG_ENTRY,
      oss_pkg::CMD_PWD_ENTRY, oss_pkg::CMD_PLK_ENTRY, oss_pkg::CMD_GRD_ENTRY, oss_pkg::CMD_VLK_ENTRY};
   logic [3:0] spc [6] = '{oss_pkg::OSS_ECC, oss_pkg::OSS_PCFG, oss_pkg::OSS_PWD,
      oss_pkg::OSS_PLK, oss_pkg::OSS_GRD, oss_pkg::OSS_VLK};
   logic [15:0] crc [5] = '{oss_pkg::CMD_CRC_START, oss_pkg::CMD_CRC_END, oss_pkg::CMD_CRC_SUSP,
      oss_pkg::CMD_CRC_RESUME, oss_pkg::CMD_CRC_RDVAL};
   oss_overlay_space_select #(.SECT_W(SW), .WORD_W(WW), .SEC_WORDS(SECW)) u_dut (
      .i_clk, .i_rst_b, .i_cmd_valid, .i_cmd_sector, .i_cmd_word, .i_cmd_data, .i_rd_start,
      .i_rd_beat, .i_rd_sector, .i_rd_word, .i_status, .i_op_busy, .i_erase_susp,
      .i_err_active, .i_timeout_set, .o_space, .o_rd_src, .o_rd_word, .o_rd_undef, .o_sec_prog,
      .o_pcfg_prog, .o_pwd_prog, .o_pwd_unlock, .o_crc_cmd, .o_crc_code, .o_crc_susp,
      .o_ctrl_standby, .o_erase_susp_state, .o_timeout_flag, .o_guard_bit, .o_plk, .o_vlk);
   oss_host_model #(.SECT_W(SW), .WORD_W(WW)) u_host (
      .i_clk(i_clk), .o_cmd_valid(i_cmd_valid), .o_cmd_sector(i_cmd_sector),
      .o_cmd_word(i_cmd_word), .o_cmd_data(i_cmd_data), .o_rd_start(i_rd_start),
      .o_rd_beat(i_rd_beat), .o_rd_sector(i_rd_sector), .o_rd_word(i_rd_word));
   task automatic chk_val(input logic [31:0] a, input logic [31:0] b);
      num_checks++;
      if (a !== b) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, a, b);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [15:0] d, input logic [SW-1:0] sec, input logic [WW-1:0] w);
      u_host.wr(sec, w, d);
   endtask
   // note: {check src, check word, undef, src, word}
   task automatic rdx(input logic first, input logic [SW-1:0] sec, input logic [WW-1:0] w,
                      input logic [2:0] flags, input logic [3:0] src, input logic [15:0] wd);
      exp_q.push_back({flags, src, wd});
      u_host.rd(first, sec, w);
   endtask
   always @(posedge i_clk) taken_q <= i_rd_start | i_rd_beat;
   always @(negedge i_clk) begin
      if (taken_q && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[22]) `CHK(o_rd_src, e[19:16]);
         if (e[21]) `CHK(o_rd_word, e[15:0]);
         `CHK(o_rd_undef, e[20]);
      end
   end
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   initial begin
      repeat (50000) @(posedge i_clk);
      n_mismatch++;
      $display("run limit reached at %0t", $time);
      give_verdict();
   end
   initial begin
      {i_rst_b, i_op_busy, i_erase_susp, i_err_active, i_timeout_set} = '0;
      i_status = '0;
      void'($urandom(45773));
      repeat (6) @(posedge i_clk);
      #1 i_rst_b = 1'b1;
      `CHK({o_space, o_guard_bit, o_ctrl_standby, |o_plk, |o_vlk}, 8'h0c);
      $display("test reset done");
      s = SW'($urandom_range(254, 1));
      wr(oss_pkg::CMD_ID_ENTRY, s, 12'h554);
      `CHK(o_space, oss_pkg::OSS_ARRAY);
      wr(oss_pkg::CMD_ID_ENTRY, s, oss_pkg::ADDR_ID_ENTRY);
      `CHK(o_space, oss_pkg::OSS_IDQ);
      rdx(1'b1, s, 12'h010, 3'b100, oss_pkg::SRC_QUERY, 16'h0000);
      rdx(1'b1, s + 8'h01, 12'h010, 3'b100, oss_pkg::SRC_ARRAY, 16'h0000);
      i_status = 16'($urandom());
      snap = i_status;
      wr(oss_pkg::CMD_SR_READ, s, 12'h000);
      `CHK(o_space, oss_pkg::OSS_STAT);
      i_status = ~snap;
      rdx(1'b1, s, 12'h000, 3'b110, oss_pkg::SRC_STAT, snap);
      `CHK(o_space, oss_pkg::OSS_IDQ);
      i_timeout_set = 1'b1;
      @(posedge i_clk);
      #1 i_timeout_set = 1'b0;
      i_op_busy = 1'b1;
      wr(oss_pkg::CMD_EXIT, 8'h00, 12'h000);
      `CHK({o_space, o_timeout_flag}, 5'h03);
      i_op_busy = 1'b0;
      wr(oss_pkg::CMD_EXIT, 8'h00, 12'h000);
      `CHK({o_space, o_timeout_flag, o_ctrl_standby}, 6'h01);
      $display("test query status reset done");
      foreach (ent[i]) begin
         i_op_busy = 1'b1;
         wr(ent[i], s, 12'h000);
         `CHK(o_space, oss_pkg::OSS_ARRAY);
         i_op_busy = 1'b0;
         wr(ent[i], SW'($urandom()), 12'h000);
         `CHK(o_space, spc[i]);
         wr((i % 2) ? oss_pkg::CMD_LEG_EXIT : oss_pkg::CMD_EXIT, 8'h00, 12'h000);
         `CHK(o_space, oss_pkg::OSS_ARRAY);
      end
      $display("test entry exit done");
      wr(oss_pkg::CMD_PCFG_ENTRY, s, 12'h000);
      rdx(1'b1, 8'h00, 12'h000, 3'b100, oss_pkg::SRC_PCFG, 16'h0000);
      wr(oss_pkg::CMD_PROG, s, 12'h000);
      wr(16'h5a5a, s, 12'h000);
      `CHK(o_pcfg_prog, 1'b1);
      rdx(1'b1, s, 12'h001, 3'b001, oss_pkg::SRC_PCFG, 16'h0000);
      i_err_active = 1'b1;
      wr(oss_pkg::CMD_SR_CLEAR, 8'h00, 12'h000);
      i_err_active = 1'b0;
      `CHK(o_space, oss_pkg::OSS_PCFG);
      wr(oss_pkg::CMD_LEG_EXIT, 8'h00, 12'h000);
      wr(oss_pkg::CMD_PWD_ENTRY, s, 12'h000);
      rdx(1'b1, 8'h00, oss_pkg::PWD_LAST_WORD, 3'b100, oss_pkg::SRC_PWD, 16'h0000);
      rdx(1'b1, s, 12'h004, 3'b001, oss_pkg::SRC_PWD, 16'h0000);
      wr(oss_pkg::CMD_PWD_UNLOCK, 8'h00, 12'h000);
      `CHK(o_pwd_unlock, 1'b1);
      wr(oss_pkg::CMD_EXIT, 8'h00, 12'h000);
      wr(oss_pkg::CMD_VLK_ENTRY, s, 12'h000);
      wr(oss_pkg::CMD_PROG, s, 12'h000);
      wr(16'h0001, s, 12'h000);
      `CHK(o_vlk[s], 1'b1);
      rdx(1'b1, s, 12'h07f, 3'b100, oss_pkg::SRC_LOCK, 16'h0000);
      `CHK(o_rd_word[0], 1'b1);
      wr(oss_pkg::CMD_PROG, s, 12'h000);
      wr(16'h0000, s, 12'h000);
      `CHK(o_vlk[s], 1'b0);
      wr(oss_pkg::CMD_EXIT, 8'h00, 12'h000);
      wr(oss_pkg::CMD_PLK_ENTRY, s, 12'h000);
      wr(oss_pkg::CMD_PROG, s, 12'h000);
      wr(16'h0001, s, 12'h000);
      `CHK(o_plk[s], 1'b1);
      wr(oss_pkg::CMD_PLK_ERASE, s, 12'h000);
      `CHK(|o_plk, 1'b0);
      wr(oss_pkg::CMD_LEG_EXIT, 8'h00, 12'h000);
      i_rst_b = 1'b0;
      repeat (2) @(posedge i_clk);
      #1 i_rst_b = 1'b1;
      `CHK(o_guard_bit, 1'b1);
      wr(oss_pkg::CMD_GRD_ENTRY, s, 12'h000);
      wr(oss_pkg::CMD_PROG, s, 12'h000);
      wr(16'h0000, s, 12'h000);
      rdx(1'b1, s - 8'h01, 12'h123, 3'b100, oss_pkg::SRC_LOCK, 16'h0000);
      `CHK({o_guard_bit, o_rd_word[0]}, 2'b00);
      wr(oss_pkg::CMD_EXIT, 8'h00, 12'h000);
      $display("test lock spaces done");
      wr(oss_pkg::CMD_SEC_ENTRY, s, 12'h000);
      rdx(1'b1, s, 12'h000, 3'b100, oss_pkg::SRC_SEC, 16'h0000);
      rdx(1'b0, s, WW'(SECW), 3'b001, oss_pkg::SRC_SEC, 16'h0000);
      rdx(1'b1, s + 8'h01, 12'h000, 3'b100, oss_pkg::SRC_ARRAY, 16'h0000);
      rdx(1'b0, s + 8'h01, 12'h001, 3'b100, oss_pkg::SRC_ARRAY, 16'h0000);
      `CHK(o_space, oss_pkg::OSS_SEC);
      wr(oss_pkg::CMD_PROG, s, 12'h000);
      wr(16'h1234, s, 12'h002);
      `CHK(o_sec_prog, 1'b1);
      wr(oss_pkg::CMD_BUF_PROG, s, 12'h000);
      wr(16'h4321, s, 12'h003);
      `CHK(o_sec_prog, 1'b1);
      wr(oss_pkg::CMD_SEC_EXIT, 8'h00, 12'h000);
      `CHK(o_space, oss_pkg::OSS_ARRAY);
      $display("test secure done");
      wr(oss_pkg::CMD_CRC_ENTRY, s, 12'h000);
      rdx(1'b1, s, 12'h000, 3'b100, oss_pkg::SRC_CRC, 16'h0000);
      foreach (crc[i]) begin
         wr(crc[i], s, 12'h000);
         `CHK({o_crc_susp, o_crc_cmd, o_crc_code}, {i == 2, 1'b1, 3'(i + 1)});
         if (i == 2) rdx(1'b1, s, 12'h000, 3'b100, oss_pkg::SRC_ARRAY, 16'h0000);
      end
      wr(oss_pkg::CMD_EXIT, 8'h00, 12'h000);
      `CHK(o_space, oss_pkg::OSS_ARRAY);
      {i_erase_susp, i_err_active} = 2'b11;
      wr(oss_pkg::CMD_SR_CLEAR, 8'h00, 12'h000);
      `CHK(o_erase_susp_state, 1'b1);
      {i_erase_susp, i_err_active} = 2'b00;
      $display("test crc error done");
      repeat (3) @(posedge i_clk);
      give_verdict();
   end
endmodule
`default_nettype wire
